// ==== inc/pfs_pkg.sv ====
/*
  pfs_pkg: constants, state encodings and carrier structs for the
  protection fault supervisor.
  assumes: all comparator flags are digital levels from the analog front end.
*/
package pfs_pkg;

  // consecutive switching cycles needed for the counted faults
  localparam logic [2:0] PFS_OVP_CYCLES  = 3'h4;
  localparam logic [2:0] PFS_OCP2_CYCLES = 3'h2;
  localparam logic [2:0] PFS_CNT_RST     = 3'h0;

  // auto-restart retry: restart attempts are PFS_RETRY_CYCLES_INT + 1 switching cycles apart
  localparam int unsigned PFS_RETRY_CYCLES_INT = 64;
  localparam logic [7:0]  PFS_RETRY_CYCLES     = 8'(PFS_RETRY_CYCLES_INT);
  localparam logic [7:0]  PFS_RETRY_RST        = 8'h00;

  // printed thresholds, kept for reference by the analog side (millivolts, deg C)
  localparam int unsigned PFS_UVLO_NORMAL_MV   = 9400;
  localparam int unsigned PFS_UVLO_LIGHT_MV    = 7200;
  localparam int unsigned PFS_MAINS_RESTART_MV = 450;
  localparam int unsigned PFS_OTP_ON_DEGC      = 160;
  localparam int unsigned PFS_OTP_OFF_DEGC     = 110;

  typedef enum logic [2:0] {
    PFS_ST_RUN   = 3'h1,
    PFS_ST_AUTO  = 3'h2,
    PFS_ST_LATCH = 3'h4
  } pfs_state_t;

  // comparator flags, all active high
  typedef struct packed {
    logic zcd_ovp;          // zero_current_detect_in above ovp threshold
    logic ff_latch;         // line_feedforward_in above latch threshold
    logic ff_off;           // line_feedforward_in above off threshold
    logic amp_at_max;       // error_amp_level at its maximum
    logic ss_above_dis;     // soft-start above softstart_disable_threshold
    logic ss_above_lat;     // soft-start above softstart_latch_threshold
    logic cs_ocp2;          // second-level overcurrent
    logic dis_otp;          // disable_in above external otp threshold
    logic tj_hot;           // junction above 160 C
    logic tj_cool;          // junction below 110 C
    logic mains_low;        // mains_sense_in below brownout threshold
    logic mains_restart;    // mains_sense_in below 0.45 V
    logic ref_ov;           // reference above drift threshold
    logic amp_low;          // error_amp_level below amp_shutdown_threshold
    logic amp_light_load;   // light-load undervoltage setting selected
    logic vcc_below_9v4;    // supply below normal turn-off level
    logic vcc_below_7v2;    // supply below light-load turn-off level
  } pfs_flags_t;

  typedef struct packed {
    logic gate_en;          // gate driver enabled
    logic ref_en;           // reference on
    logic ss_discharge;     // force soft-start to zero
    logic osc_hold_high;    // oscillator output held at 1
    logic freq_modulation_out_hold;        // freq_modulation_out frozen
    logic ff_discharge;     // line_feedforward_in pulled to zero
    logic latched;          // latched fault state
    logic auto_fault;       // auto-restart fault state
  } pfs_ctrl_t;

  localparam pfs_ctrl_t PFS_CTRL_RST = '{
    gate_en: 1'b0, ref_en: 1'b0, ss_discharge: 1'b1, osc_hold_high: 1'b0,
    freq_modulation_out_hold: 1'b0, ff_discharge: 1'b0, latched: 1'b0, auto_fault: 1'b0};

endpackage : pfs_pkg

// ==== rtl/pfs_cycle_counter.sv ====
/*
  pfs_cycle_counter: counts consecutive switching cycles with a condition high.
  assumes: cyc_en_i is a one-clock pulse per switching cycle, cond_i synchronised.
*/
`timescale 1ns/10ps
module pfs_cycle_counter (
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             cyc_en_i,
  input  wire logic             cond_i,
  input  wire logic [2:0]       limit_i,
  output logic                  hit_o
);
  import pfs_pkg::*;

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (!cond_i) begin
      cnt_d = PFS_CNT_RST;
    end else if (cyc_en_i && (cnt_q != limit_i)) begin
      cnt_d = cnt_q + 3'h1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= PFS_CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign hit_o = cond_i && (cnt_q == limit_i);

endmodule : pfs_cycle_counter

// ==== rtl/pfs_supervisor.sv ====
/*
  pfs_supervisor: fault supervisor gating gate driver, reference and soft-start.
  assumes: clk_i is the controller clock; cyc_en_i marks each switching cycle;
  comparator flags arrive asynchronously and are synchronised here.
*/
`timescale 1ns/10ps
module pfs_supervisor (
  input  wire logic                clk_i,
  input  wire logic                arst_n_i,
  input  wire logic                cyc_en_i,
  input  wire pfs_pkg::pfs_flags_t flags_i,
  output pfs_pkg::pfs_ctrl_t       ctrl_o,
  output pfs_pkg::pfs_state_t      state_o
);
  import pfs_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  pfs_flags_t sync1_q;
  pfs_flags_t sync2_q;
  logic       cyc_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= flags_i;
      sync2_q <= sync1_q;
    end
  end

  assign cyc_q = cyc_en_i;

  //////////////////////////////////////////////////////////////////////////////
  // consecutive-cycle counters

  logic ovp_hit;
  logic ocp2_hit;

  pfs_cycle_counter u_ovp_cnt (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .cyc_en_i (cyc_q),
    .cond_i   (sync2_q.zcd_ovp),
    .limit_i  (PFS_OVP_CYCLES),
    .hit_o    (ovp_hit)
  );

  pfs_cycle_counter u_ocp2_cnt (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .cyc_en_i (cyc_q),
    .cond_i   (sync2_q.cs_ocp2),
    .limit_i  (PFS_OCP2_CYCLES),
    .hit_o    (ocp2_hit)
  );

  //////////////////////////////////////////////////////////////////////////////
  // fault classification

  logic uvlo;
  logic overload;
  logic ovl_latch;
  logic otp_hot_q;
  logic otp_hot_d;
  logic latch_cause;
  logic auto_cause;
  logic brownout;

  always_comb begin
    uvlo = sync2_q.amp_light_load ? sync2_q.vcc_below_7v2
                                  : sync2_q.vcc_below_9v4;
    overload  = sync2_q.amp_at_max && sync2_q.ss_above_dis;
    // soft-start crossing latch level before undervoltage latches
    ovl_latch = overload && sync2_q.ss_above_lat && !uvlo;
    otp_hot_d = otp_hot_q;
    if (sync2_q.tj_hot) begin
      otp_hot_d = 1'b1;
    end else if (sync2_q.tj_cool) begin
      otp_hot_d = 1'b0;
    end
    brownout = sync2_q.mains_low;
    latch_cause = sync2_q.ff_latch
                | ovl_latch
                | ocp2_hit
                | sync2_q.dis_otp
                | sync2_q.ref_ov
                | sync2_q.amp_low;
    auto_cause  = ovp_hit
                | (overload && uvlo)
                | otp_hot_d
                | brownout
                | sync2_q.ff_off
                | uvlo;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      otp_hot_q <= 1'b0;
    end else begin
      otp_hot_q <= otp_hot_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state machine

  pfs_state_t state_q;
  pfs_state_t state_d;
  logic [7:0] retry_q;
  logic [7:0] retry_d;

  always_comb begin
    state_d = state_q;
    retry_d = retry_q;
    case (state_q)
      PFS_ST_RUN: begin
        if (latch_cause) begin
          state_d = PFS_ST_LATCH;
        end else if (auto_cause) begin
          state_d = PFS_ST_AUTO;
          retry_d = PFS_RETRY_RST;
        end
      end
      PFS_ST_AUTO: begin
        if (latch_cause) begin
          state_d = PFS_ST_LATCH;
        end else if (cyc_q) begin
          if (retry_q == PFS_RETRY_CYCLES) begin
            retry_d = PFS_RETRY_RST;
            // retry attempt: leave only if the cause has cleared
            if (!auto_cause) begin
              state_d = PFS_ST_RUN;
            end
          end else begin
            retry_d = retry_q + 8'h01;
          end
        end
      end
      PFS_ST_LATCH: begin
        if (sync2_q.mains_restart) begin
          state_d = PFS_ST_RUN;
        end else begin
          state_d = PFS_ST_LATCH;
        end
      end
      default: begin
        state_d = PFS_ST_LATCH;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= PFS_ST_RUN;
      retry_q <= PFS_RETRY_RST;
    end else begin
      state_q <= state_d;
      retry_q <= retry_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output control

  pfs_ctrl_t ctrl_d;
  pfs_ctrl_t ctrl_q;
  logic      ff_only;

  always_comb begin
    ctrl_d = '0;
    ff_only = sync2_q.ff_off && !ovp_hit && !overload && !otp_hot_d
           && !brownout && !uvlo;
    case (state_d)
      PFS_ST_RUN: begin
        ctrl_d.gate_en = 1'b1;
        ctrl_d.ref_en  = 1'b1;
      end
      PFS_ST_AUTO: begin
        ctrl_d.auto_fault = 1'b1;
        if (ff_only) begin
          ctrl_d.ref_en        = 1'b1;
          ctrl_d.osc_hold_high = 1'b1;
          ctrl_d.freq_modulation_out_hold     = 1'b1;
        end else if ((ovp_hit || overload) && !brownout && !otp_hot_d) begin
          ctrl_d.ref_en = 1'b1;
        end else begin
          ctrl_d.ss_discharge = 1'b1;
        end
      end
      PFS_ST_LATCH: begin
        ctrl_d.latched      = 1'b1;
        ctrl_d.ss_discharge = 1'b1;
        ctrl_d.ff_discharge = 1'b1;
      end
      default: begin
        ctrl_d = PFS_CTRL_RST;
      end
    endcase
    if (uvlo) begin
      ctrl_d.ss_discharge = 1'b1;
      ctrl_d.ref_en       = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q <= PFS_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  assign ctrl_o  = ctrl_q;
  assign state_o = state_q;

endmodule : pfs_supervisor

// ==== testbench/pfs_supervisor_properties.sv ====
/*
  pfs_supervisor_properties: port assertions for the fault supervisor.
  assumes: bound to pfs_supervisor; one clock domain.
*/
`timescale 1ns/10ps
module pfs_supervisor_properties (
  input  wire logic                clk_i,
  input  wire logic                arst_n_i,
  input  wire logic                cyc_en_i,
  input  wire pfs_pkg::pfs_flags_t flags_i,
  input  wire pfs_pkg::pfs_ctrl_t  ctrl_o,
  input  wire pfs_pkg::pfs_state_t state_o
);
  import pfs_pkg::*;
  logic lat_c;
  assign lat_c = flags_i.ff_latch | flags_i.dis_otp | flags_i.ref_ov | flags_i.amp_low;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  //////////////////////////////////////////////////////////////////////////////
  a_latch_stops: assert property (state_o == PFS_ST_LATCH |->
    !ctrl_o.gate_en && !ctrl_o.ref_en && ctrl_o.ss_discharge) else $error("latch outputs");
  a_auto_gate_off: assert property (state_o == PFS_ST_AUTO |-> !ctrl_o.gate_en)
    else $error("gate on in auto");
  a_run_gate_on: assert property (state_o == PFS_ST_RUN && $past(arst_n_i) |->
    ctrl_o.gate_en && ctrl_o.ref_en) else $error("gate off in run");
  a_cause_latches: assert property ((lat_c && !flags_i.mains_restart)[*4] |=>
    state_o == PFS_ST_LATCH) else $error("latch cause ignored");
  a_latch_holds: assert property ((state_o == PFS_ST_LATCH && !flags_i.mains_restart)[*4] |=>
    state_o == PFS_ST_LATCH) else $error("latch left");
  a_restart_frees: assert property ((flags_i.mains_restart && !lat_c)[*4] |=>
    state_o != PFS_ST_LATCH) else $error("restart ignored");
  a_uvlo_discharge: assert property ((flags_i.vcc_below_9v4 && !flags_i.amp_light_load)[*4] |=>
    ctrl_o.ss_discharge && !ctrl_o.ref_en) else $error("uvlo outputs");
  a_light_uvlo: assert property ((flags_i.vcc_below_7v2 && flags_i.amp_light_load)[*4] |=>
    ctrl_o.ss_discharge && !ctrl_o.ref_en) else $error("light uvlo outputs");
  a_brownout_stop: assert property (flags_i.mains_low[*4] |=>
    !ctrl_o.ref_en && ctrl_o.ss_discharge && state_o != PFS_ST_RUN) else $error("brownout");
  a_state_agree: assert property (ctrl_o.latched == (state_o == PFS_ST_LATCH) &&
    ctrl_o.auto_fault == (state_o == PFS_ST_AUTO)) else $error("state flags disagree");
  c_latch: cover property (state_o == PFS_ST_LATCH);
  c_auto: cover property (state_o == PFS_ST_AUTO);
  c_resume: cover property ($past(state_o) == PFS_ST_AUTO && state_o == PFS_ST_RUN);
endmodule : pfs_supervisor_properties

bind pfs_supervisor pfs_supervisor_properties u_props (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .cyc_en_i(cyc_en_i), .flags_i(flags_i), .ctrl_o(ctrl_o), .state_o(state_o));

// ==== testbench/pfs_supervisor_test.sv ====
/*
  pfs_supervisor_test: self-checking bench for the fault supervisor.
  assumes: comparator flags and switching cycles are driven here directly.
*/
`timescale 1ns/10ps
module pfs_supervisor_test;
  import pfs_pkg::*;
  logic       clk_i;
  logic       arst_n_i;
  logic       cyc_en_i;
  pfs_flags_t flags_i;
  pfs_flags_t f;
  pfs_ctrl_t  ctrl_o;
  pfs_state_t state_o;
  int         errors;
  int         compares;
  pfs_supervisor DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .cyc_en_i(cyc_en_i),
    .flags_i(flags_i), .ctrl_o(ctrl_o), .state_o(state_o));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc
  task automatic see(input pfs_state_t s);
    for (int i = 0; i < 12 && state_o !== s; i++) @(negedge clk_i);
    check("state", 8'(state_o), 8'(s));
  endtask : see
  //////////////////////////////////////////////////////////////////////////////
  task automatic latch_case(input pfs_flags_t c);
    flags_i = c;
    see(PFS_ST_LATCH);
    check("latch out", 8'({ctrl_o.gate_en, ctrl_o.ref_en, ctrl_o.ff_discharge}), 8'h01);
    cyc(2);
    flags_i = '0;
    cyc(20);
    see(PFS_ST_LATCH);
    flags_i.mains_restart = 1'b1;
    see(PFS_ST_RUN);
    check("restart", 8'({ctrl_o.gate_en, ctrl_o.ref_en}), 8'h03);
    cyc(2);
    flags_i = '0;
    cyc(4);
  endtask : latch_case
  task automatic auto_case(input pfs_flags_t c, input pfs_flags_t m, input pfs_flags_t e,
                           input logic [2:0] x);
    flags_i = c;
    see(PFS_ST_AUTO);
    check("auto out", 8'({ctrl_o.gate_en, ctrl_o.ff_discharge, ctrl_o.ref_en,
      ctrl_o.ss_discharge, ctrl_o.osc_hold_high}), 8'(x));
    check("freq_modulation_out hold", 8'(ctrl_o.freq_modulation_out_hold), 8'(x[0]));
    flags_i = m;
    cyc(80);
    see(PFS_ST_AUTO);
    flags_i = e;
    cyc(70);
    see(PFS_ST_RUN);
    flags_i = '0;
    cyc(4);
  endtask : auto_case
  task automatic t_ovp();
    cyc_en_i = 1'b0;
    flags_i.zcd_ovp = 1'b1;
    cyc(6);
    for (int i = 0; i < 4; i++) begin
      check("ovp count", 8'(state_o), 8'(PFS_ST_RUN));
      cyc_en_i = 1'b1;
      cyc(1);
      cyc_en_i = 1'b0;
      cyc(2);
    end
    see(PFS_ST_AUTO);
    check("ovp out", 8'({ctrl_o.gate_en, ctrl_o.ref_en, ctrl_o.ss_discharge}), 8'h02);
    flags_i = '0;
    cyc_en_i = 1'b1;
    cyc(70);
    see(PFS_ST_RUN);
  endtask : t_ovp
  task automatic t_power();
    flags_i.dis_otp = 1'b1;
    see(PFS_ST_LATCH);
    flags_i = '0;
    arst_n_i = 1'b0;
    cyc(2);
    check("reset out", 8'(ctrl_o), 8'(PFS_CTRL_RST));
    arst_n_i = 1'b1;
    cyc(2);
    see(PFS_ST_RUN);
  endtask : t_power
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n_i = 1'b0;
    cyc_en_i = 1'b1;
    flags_i = '0;
    cyc(3);
    check("reset out", 8'(ctrl_o), 8'(PFS_CTRL_RST));
    arst_n_i = 1'b1;
    cyc(2);
    check("run out", 8'({ctrl_o.gate_en, ctrl_o.ref_en}), 8'h03);
    f = '0;
    f.ff_latch = 1'b1;
    latch_case(f);
    f = '0;
    f.ref_ov = 1'b1;
    latch_case(f);
    f.ref_ov = 1'b0;
    f.amp_low = 1'b1;
    latch_case(f);
    f = '0;
    f.cs_ocp2 = 1'b1;
    latch_case(f);
    f = '0;
    f.dis_otp = 1'b1;
    f.mains_low = 1'b1;
    latch_case(f);
    f = '0;
    f.amp_at_max = 1'b1;
    f.ss_above_dis = 1'b1;
    f.ss_above_lat = 1'b1;
    latch_case(f);
    f.ss_above_lat = 1'b0;
    f.vcc_below_9v4 = 1'b1;
    auto_case(f, f, '0, 3'h2);
    f = '0;
    f.mains_low = 1'b1;
    auto_case(f, f, '0, 3'h2);
    f = '0;
    f.ff_off = 1'b1;
    auto_case(f, f, '0, 3'h5);
    f = '0;
    f.vcc_below_9v4 = 1'b1;
    auto_case(f, f, '0, 3'h2);
    f.amp_light_load = 1'b1;
    flags_i = f;
    cyc(10);
    check("light ok", 8'(state_o), 8'(PFS_ST_RUN));
    f.vcc_below_7v2 = 1'b1;
    auto_case(f, f, '0, 3'h2);
    f = '0;
    f.tj_hot = 1'b1;
    flags_i = '0;
    flags_i.tj_cool = 1'b1;
    auto_case(f, '0, flags_i, 3'h2);
    t_ovp();
    t_power();
    test_done();
  end
  initial begin
    #100us;
    errors++;
    test_done();
  end
endmodule : pfs_supervisor_test
